//--- verilog/sdb_defines.svh
// sdb_defines.svh: widths, mode fields, encodings and reset values
`ifndef SDB_DEFINES_SVH
`define SDB_DEFINES_SVH

// ****************************************************************
// array geometry (x8 organisation: 1,024 columns per row)
// ****************************************************************
`define SDB_COL_W 10
`define SDB_ROW_W 13
`define SDB_DQ_W 8
`define SDB_BANKS 4
`define SDB_ROW_KEEP 2
`define SDB_MEM_AW 14
`define SDB_MEM_DEPTH 16384

// ****************************************************************
// address pin fields
// ****************************************************************
`define SDB_OP_MSB 11
`define SDB_AP_BIT 10

// ****************************************************************
// mode word fields
// ****************************************************************
`define SDB_BL_MSB 2
`define SDB_BL_LSB 0
`define SDB_BT_BIT 3
`define SDB_CL_MSB 6
`define SDB_CL_LSB 4
`define SDB_WBM_BIT 9
`define SDB_MODE_RST 12'h032

// ****************************************************************
// burst length and read latency encodings
// ****************************************************************
`define SDB_BL1 3'h0
`define SDB_BL2 3'h1
`define SDB_BL4 3'h2
`define SDB_BL8 3'h3
`define SDB_BLPG 3'h7
`define SDB_CL3 3'h3

// ****************************************************************
// block masks, also the last burst index
// ****************************************************************
`define SDB_MASK1 10'h000
`define SDB_MASK2 10'h001
`define SDB_MASK4 10'h003
`define SDB_MASK8 10'h007
`define SDB_MASKPG 10'h3ff
`define SDB_IDX0 10'h000
`define SDB_IDX1 10'h001

`endif

//--- verilog/sdb_pkg.sv
// sdb_pkg.sv: command and burst engine types
package sdb_pkg;

    typedef enum logic [3:0] {
        SDB_INHIBIT,
        SDB_NOP,
        SDB_ACTIVE,
        SDB_READ,
        SDB_WRITE,
        SDB_BTERM,
        SDB_PRECH,
        SDB_REFRESH,
        SDB_LOAD_MODE
    } sdb_cmd_t;

    typedef enum logic [1:0] {
        SDB_IDLE,
        SDB_RD,
        SDB_WR
    } sdb_burst_st_t;

endpackage : sdb_pkg

//--- verilog/sdb_burst_seq.sv
// sdb_burst_seq.sv: column of the k-th access within a burst
`include "sdb_defines.svh"

module sdb_burst_seq (
    input wire logic [`SDB_COL_W-1:0] start_col, // supplied start column
    input wire logic [`SDB_COL_W-1:0] idx, // access number k in the burst
    input wire logic [`SDB_COL_W-1:0] mask, // ones mark the in-block bits
    input wire logic interleave, // interleaved instead of sequential
    output logic [`SDB_COL_W-1:0] col // column to access
);
    logic [`SDB_COL_W-1:0] sum;
    logic [`SDB_COL_W-1:0] mix;

    // carries out of the block bits are thrown away by the mask
    assign sum = start_col + idx;
    assign mix = interleave ? (start_col ^ idx) : sum;

    genvar i;
    generate
        for (i = 0; i < `SDB_COL_W; i = i + 1) begin : g_bit
            // block bits fixed, only the low bits move: wrap in block
            assign col[i] = mask[i] ? mix[i] : start_col[i];
        end
    endgenerate

endmodule : sdb_burst_seq

//--- verilog/sdb_core.sv
// sdb_core.sv: command decode, burst sequencing and read latency
// ****************************************************************
// ****************************************************************
`include "sdb_defines.svh"

module sdb_core
    import sdb_pkg::*;
(
    input wire logic clk, // system clock, rising edge
    input wire logic nrst, // asynchronous reset, active low
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select, active low
    input wire logic ras_n, // row strobe, active low
    input wire logic cas_n, // column strobe, active low
    input wire logic we_n, // write enable, active low
    input wire logic [1:0] bank_select, // bank number
    input wire logic [`SDB_ROW_W-1:0] addr, // address pins
    input wire logic data_mask, // lane mask
    input wire logic [`SDB_DQ_W-1:0] dq_in, // data pins, input side
    output logic [`SDB_DQ_W-1:0] dq_out, // data pins, output side
    output logic dq_oe, // data pins driven while high
    output logic [`SDB_BANKS-1:0] bank_open, // one bit per open bank
    output logic self_refresh, // in self refresh
    output logic [`SDB_ROW_W-1:0] refresh_row, // internal refresh row
    output logic [`SDB_OP_MSB:0] mode_word // programmed mode word
);

    // ****************************************************************
    // state
    // ****************************************************************
    logic [`SDB_DQ_W-1:0] mem [0:`SDB_MEM_DEPTH-1];

    sdb_burst_st_t st_r, st_nxt;
    logic [1:0] bank_r, bank_nxt;
    logic [`SDB_COL_W-1:0] start_r, start_nxt;
    logic [`SDB_COL_W-1:0] idx_r, idx_nxt;
    logic [`SDB_COL_W-1:0] last_r, last_nxt;
    logic [`SDB_COL_W-1:0] mask_r, mask_nxt;
    logic inter_r, inter_nxt;
    logic page_r, page_nxt;
    logic ap_r, ap_nxt;

    logic [`SDB_ROW_W-1:0] row_r [0:`SDB_BANKS-1];
    logic [`SDB_ROW_W-1:0] row_nxt [0:`SDB_BANKS-1];
    logic [`SDB_BANKS-1:0] open_r, open_nxt;
    logic sr_r, sr_nxt;
    logic [`SDB_ROW_W-1:0] rcnt_r, rcnt_nxt;
    logic [`SDB_OP_MSB:0] mode_r, mode_nxt;

    logic p1_vld_r, p1_vld_nxt;
    logic [`SDB_DQ_W-1:0] p1_dat_r, p1_dat_nxt;
    logic dqm_r, dqm_nxt;
    logic [`SDB_DQ_W-1:0] dq_out_r, dq_out_nxt;
    logic dq_oe_r, dq_oe_nxt;

    // ****************************************************************
    // decoding
    // ****************************************************************
    sdb_cmd_t cmd_raw;
    sdb_cmd_t cmd;
    logic [`SDB_COL_W-1:0] cmd_col;
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    logic [`SDB_COL_W-1:0] mask_mode;
    logic bl_page;
    logic inter_mode;
    logic wr_single;

    logic [`SDB_COL_W-1:0] seq_start;
    logic [`SDB_COL_W-1:0] seq_idx;
    logic [`SDB_COL_W-1:0] seq_mask;
    logic seq_inter;
    logic [`SDB_COL_W-1:0] acc_col;
    logic [1:0] acc_bank;
    logic [`SDB_MEM_AW-1:0] acc_addr;
    logic wr_now;
    logic rd_now;
    logic mem_we;
    logic [`SDB_DQ_W-1:0] rd_word;
    logic out_vld;
    logic [`SDB_DQ_W-1:0] out_dat;

    assign cmd_col = addr[`SDB_COL_W-1:0];
    assign bl_code = mode_r[`SDB_BL_MSB:`SDB_BL_LSB];
    assign cl_code = mode_r[`SDB_CL_MSB:`SDB_CL_LSB];
    assign wr_single = mode_r[`SDB_WBM_BIT];
    assign bl_page = (bl_code == `SDB_BLPG);
    // full page is sequential only, so the type bit is ignored there
    assign inter_mode = mode_r[`SDB_BT_BIT] & ~bl_page;

    always_comb begin
        unique case (bl_code)
            `SDB_BL2: mask_mode = `SDB_MASK2;
            `SDB_BL4: mask_mode = `SDB_MASK4;
            `SDB_BL8: mask_mode = `SDB_MASK8;
            `SDB_BLPG: mask_mode = `SDB_MASKPG;
            // length one and reserved codes: single column, type moot
            default: mask_mode = `SDB_MASK1;
        endcase
    end

    always_comb begin
        unique casez ({cs_n, ras_n, cas_n, we_n})
            4'b1???: cmd_raw = SDB_INHIBIT;
            4'b0111: cmd_raw = SDB_NOP;
            4'b0011: cmd_raw = SDB_ACTIVE;
            4'b0101: cmd_raw = SDB_READ;
            4'b0100: cmd_raw = SDB_WRITE;
            4'b0110: cmd_raw = SDB_BTERM;
            4'b0010: cmd_raw = SDB_PRECH;
            4'b0001: cmd_raw = SDB_REFRESH;
            4'b0000: cmd_raw = SDB_LOAD_MODE;
        endcase
        // in self refresh only the clock enable is looked at;
        // with the clock enable low only refresh (self entry) counts
        if (sr_r) begin
            cmd = SDB_INHIBIT;
        end else if (!cke && cmd_raw != SDB_REFRESH) begin
            cmd = SDB_INHIBIT;
        end else begin
            cmd = cmd_raw;
        end
    end

    // ****************************************************************
    // column sequencing and array access
    // ****************************************************************
    always_comb begin
        seq_start = start_r;
        seq_idx = idx_r;
        seq_mask = mask_r;
        seq_inter = inter_r;
        acc_bank = bank_r;
        if (cmd == SDB_WRITE) begin
            // first write word goes in with the command itself
            seq_start = cmd_col;
            seq_idx = `SDB_IDX0;
            seq_mask = wr_single ? `SDB_MASK1 : mask_mode;
            seq_inter = inter_mode;
            acc_bank = bank_select;
        end
    end

    sdb_burst_seq u_seq (
        .start_col(seq_start),
        .idx(seq_idx),
        .mask(seq_mask),
        .interleave(seq_inter),
        .col(acc_col)
    );

    // rows alias modulo four: the array keeps only a slice of each bank
    assign acc_addr = {acc_bank, row_r[acc_bank][`SDB_ROW_KEEP-1:0],
                       acc_col};

    // a new read or a burst stop truncates a write burst at once
    assign wr_now = (cmd == SDB_WRITE) ||
                    (st_r == SDB_WR && cmd != SDB_READ &&
                     cmd != SDB_BTERM);
    assign mem_we = wr_now & ~data_mask;
    // a write command cuts a running read before its word is fetched
    assign rd_now = (st_r == SDB_RD) && (cmd != SDB_WRITE);
    assign rd_word = mem[acc_addr];

    // ****************************************************************
    // burst engine and bank state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        bank_nxt = bank_r;
        start_nxt = start_r;
        idx_nxt = idx_r;
        last_nxt = last_r;
        mask_nxt = mask_r;
        inter_nxt = inter_r;
        page_nxt = page_r;
        ap_nxt = ap_r;
        row_nxt = row_r;
        open_nxt = open_r;
        sr_nxt = sr_r;
        rcnt_nxt = rcnt_r;
        mode_nxt = mode_r;

        // running burst advances; inhibit and nop leave it alone
        if (st_r != SDB_IDLE) begin
            if (idx_r == last_r && !page_r) begin
                st_nxt = SDB_IDLE;
                if (ap_r) begin
                    open_nxt[bank_r] = 1'b0;
                end
            end else begin
                // full page keeps counting; the mask wraps it in the row
                idx_nxt = idx_r + `SDB_IDX1;
            end
        end

        unique case (cmd)
            SDB_ACTIVE: begin
                row_nxt[bank_select] = addr;
                open_nxt[bank_select] = 1'b1;
            end
            SDB_READ: begin
                st_nxt = SDB_RD;
                bank_nxt = bank_select;
                start_nxt = cmd_col;
                idx_nxt = `SDB_IDX0;
                mask_nxt = mask_mode;
                last_nxt = mask_mode;
                inter_nxt = inter_mode;
                page_nxt = bl_page;
                // auto precharge does not apply to full page bursts
                ap_nxt = addr[`SDB_AP_BIT] & ~bl_page;
            end
            SDB_WRITE: begin
                bank_nxt = bank_select;
                start_nxt = cmd_col;
                idx_nxt = `SDB_IDX1;
                mask_nxt = seq_mask;
                last_nxt = seq_mask;
                inter_nxt = inter_mode;
                page_nxt = bl_page & ~wr_single;
                ap_nxt = addr[`SDB_AP_BIT] & ~(bl_page & ~wr_single);
                if (seq_mask == `SDB_MASK1) begin
                    st_nxt = SDB_IDLE;
                    if (addr[`SDB_AP_BIT]) begin
                        open_nxt[bank_select] = 1'b0;
                    end
                end else begin
                    st_nxt = SDB_WR;
                end
            end
            SDB_BTERM: begin
                st_nxt = SDB_IDLE;
            end
            SDB_PRECH: begin
                if (addr[`SDB_AP_BIT]) begin
                    open_nxt = '0;
                end else begin
                    open_nxt[bank_select] = 1'b0;
                end
            end
            SDB_REFRESH: begin
                // row comes from the counter, address pins unused
                rcnt_nxt = rcnt_r + 13'h0001;
                sr_nxt = ~cke;
            end
            SDB_LOAD_MODE: begin
                mode_nxt = addr[`SDB_OP_MSB:0];
            end
            default: begin
                // inhibit and nop: nothing new is registered except the self refresh exit on a high clock enable
                if (sr_r && cke) begin
                    sr_nxt = 1'b0;
                end
            end
        endcase
    end

    // ****************************************************************
    // read latency pipeline and data pins
    // ****************************************************************
    always_comb begin
        p1_vld_nxt = rd_now;
        p1_dat_nxt = rd_word;
        dqm_nxt = data_mask;
        // latency two drives from the fetch, three from one stage later
        if (cl_code == `SDB_CL3) begin
            out_vld = p1_vld_r;
            out_dat = p1_dat_r;
        end else begin
            out_vld = rd_now;
            out_dat = rd_word;
        end
        // mask sampled at edge k floats the word valid at edge k+2
        dq_oe_nxt = out_vld & ~dqm_r;
        dq_out_nxt = out_vld ? out_dat : dq_out_r;
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= SDB_IDLE;
            bank_r <= 2'h0;
            start_r <= `SDB_IDX0;
            idx_r <= `SDB_IDX0;
            last_r <= `SDB_MASK1;
            mask_r <= `SDB_MASK1;
            inter_r <= 1'b0;
            page_r <= 1'b0;
            ap_r <= 1'b0;
            for (int b = 0; b < `SDB_BANKS; b++) begin
                row_r[b] <= 13'h0000;
            end
            open_r <= 4'h0;
            sr_r <= 1'b0;
            rcnt_r <= 13'h0000;
            mode_r <= `SDB_MODE_RST;
            p1_vld_r <= 1'b0;
            p1_dat_r <= 8'h00;
            dqm_r <= 1'b0;
            dq_out_r <= 8'h00;
            dq_oe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bank_r <= bank_nxt;
            start_r <= start_nxt;
            idx_r <= idx_nxt;
            last_r <= last_nxt;
            mask_r <= mask_nxt;
            inter_r <= inter_nxt;
            page_r <= page_nxt;
            ap_r <= ap_nxt;
            row_r <= row_nxt;
            open_r <= open_nxt;
            sr_r <= sr_nxt;
            rcnt_r <= rcnt_nxt;
            mode_r <= mode_nxt;
            p1_vld_r <= p1_vld_nxt;
            p1_dat_r <= p1_dat_nxt;
            dqm_r <= dqm_nxt;
            dq_out_r <= dq_out_nxt;
            dq_oe_r <= dq_oe_nxt;
        end
    end

    // array has no reset: contents are undefined after power-up
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[acc_addr] <= dq_in;
        end
    end

    assign dq_out = dq_out_r;
    assign dq_oe = dq_oe_r;
    assign bank_open = open_r;
    assign self_refresh = sr_r;
    assign refresh_row = rcnt_r;
    assign mode_word = mode_r;

endmodule : sdb_core

//--- sim/sdb_core_asserts.sv
// sdb_core_asserts.sv: port-level checks for sdb_core
`include "sdb_defines.svh"

module sdb_chk (
    input wire logic clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic cke, // clock enable
    input wire logic cs_n, // chip select
    input wire logic ras_n, // row strobe
    input wire logic cas_n, // column strobe
    input wire logic we_n, // write enable
    input wire logic [1:0] bank_select, // bank
    input wire logic [`SDB_ROW_W-1:0] addr, // address
    input wire logic data_mask, // lane mask
    input wire logic [`SDB_DQ_W-1:0] dq_in, // write data
    input wire logic [`SDB_DQ_W-1:0] dq_out, // read data
    input wire logic dq_oe, // data driven
    input wire logic [`SDB_BANKS-1:0] bank_open, // open banks
    input wire logic self_refresh, // self refresh
    input wire logic [`SDB_ROW_W-1:0] refresh_row, // refresh row
    input wire logic [`SDB_OP_MSB:0] mode_word // mode word
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // command decode
    // ****************
    wire logic sel = !cs_n && cke && !self_refresh;
    wire logic c_rd = sel && ras_n && !cas_n && we_n;
    wire logic c_wr = sel && ras_n && !cas_n && !we_n;
    wire logic c_bt = sel && ras_n && cas_n && !we_n;
    wire logic c_act = sel && !ras_n && cas_n && we_n;
    wire logic c_pre = sel && !ras_n && cas_n && !we_n;
    wire logic c_ld = sel && !ras_n && !cas_n && !we_n;
    wire logic c_ref = !cs_n && !ras_n && !cas_n && we_n && !self_refresh;
    wire logic [2:0] cl = mode_word[`SDB_CL_MSB:`SDB_CL_LSB];
    // a write or terminate in flight would cut the burst short
    wire logic go = !c_wr && !c_bt;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_rd2;
        c_rd && cl == 3'h2 && !data_mask ##1 go;
    endsequence
    sequence s_rd3;
        c_rd && cl == `SDB_CL3 ##1 go && !data_mask ##1 go;
    endsequence
    property p_lat2;
        s_rd2 |=> dq_oe;
    endproperty
    property p_lat3;
        s_rd3 |=> dq_oe;
    endproperty
    property p_mask;
        data_mask |-> ##2 !dq_oe;
    endproperty
    property p_ld;
        c_ld |=> mode_word == $past(addr[`SDB_OP_MSB:0]);
    endproperty
    property p_act;
        c_act |=> bank_open[$past(bank_select)];
    endproperty
    property p_pra;
        c_pre && addr[`SDB_AP_BIT] |=> bank_open == 4'h0;
    endproperty
    property p_pr1;
        c_pre && !addr[`SDB_AP_BIT] |=> !bank_open[$past(bank_select)];
    endproperty
    property p_aref;
        c_ref && cke |=> !self_refresh &&
            refresh_row == $past(refresh_row) + 13'h1;
    endproperty
    property p_sref;
        c_ref && !cke |=> self_refresh;
    endproperty
    property p_hold;
        self_refresh && !cke |=> self_refresh &&
            $stable(mode_word) && $stable(bank_open);
    endproperty
    property p_inh;
        cs_n && !self_refresh |=> !self_refresh &&
            $stable(mode_word) && $stable(refresh_row);
    endproperty

    a_lat2: assert property (p_lat2) else $error("late data, two");
    a_lat3: assert property (p_lat3) else $error("late data, three");
    a_mask: assert property (p_mask) else $error("masked lane out");
    a_ld: assert property (p_ld) else $error("mode word not loaded");
    a_act: assert property (p_act) else $error("bank not opened");
    a_pra: assert property (p_pra) else $error("banks left open");
    a_pr1: assert property (p_pr1) else $error("bank not closed");
    a_aref: assert property (p_aref) else $error("row not stepped");
    a_sref: assert property (p_sref) else $error("no self refresh");
    a_hold: assert property (p_hold) else $error("input taken");
    a_inh: assert property (p_inh) else $error("inhibit not kept");
endmodule : sdb_chk

bind sdb_core sdb_chk u_chk (
    .clk(clk), .nrst(nrst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr),
    .data_mask(data_mask), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .bank_open(bank_open), .self_refresh(self_refresh),
    .refresh_row(refresh_row), .mode_word(mode_word)
);

//--- sim/sdb_ctl_model.sv
// sdb_ctl_model.sv: memory controller model driving the command pins
module sdb_ctl_model (
    input wire logic clk, // system clock
    output logic cke, // clock enable
    output logic cs_n, // chip select
    output logic ras_n, // row strobe
    output logic cas_n, // column strobe
    output logic we_n, // write enable
    output logic [1:0] bank_select, // bank
    output logic [12:0] addr, // address
    output logic data_mask, // lane mask
    output logic [7:0] dq_in // write data
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        cke = 1'b1;
        {cs_n, ras_n, cas_n, we_n} = 4'hf;
        bank_select = 2'h0;
        addr = 13'h0000;
        data_mask = 1'b0;
        dq_in = 8'h00;
    end

    // ****************
    // one command per edge, held until the edge passes
    // ****************
    task issue(input logic [3:0] c, input logic k, input logic [1:0] b,
               input logic [12:0] a, input logic m, input logic [7:0] d);
        {cs_n, ras_n, cas_n, we_n} = c;
        cke = k;
        bank_select = b;
        addr = a;
        data_mask = m;
        dq_in = d;
        @(posedge clk);
        #1;
    endtask : issue

    // unused lines flip each cycle so a stale value never looks valid
    task nop(input logic m, input logic [7:0] d);
        issue(4'b0111, cke, ~bank_select, ~addr, m, d);
    endtask : nop

    task idle;
        nop(1'b0, ~dq_in);
    endtask : idle

    task load(input logic [11:0] op);
        issue(4'b0000, 1'b1, 2'h0, {1'b0, op}, 1'b0, ~dq_in);
    endtask : load
endmodule : sdb_ctl_model

//--- sim/tb_top.sv
// tb_top.sv: self-checking bench for sdb_core
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk, nrst, cke, cs_n, ras_n, cas_n, we_n, data_mask, dq_oe;
    logic self_refresh;
    logic [1:0] bank_select;
    logic [12:0] addr, refresh_row;
    logic [7:0] dq_in, dq_out;
    logic [3:0] bank_open;
    logic [11:0] mode_word;
    logic [9:0] pg [5] = '{10'h3fe, 10'h3ff, 10'h000, 10'h001, 10'h005};
    int n_fail;
    int checked;

    sdb_ctl_model u_ctl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
        .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select), .addr(addr),
        .data_mask(data_mask), .dq_in(dq_in));
    sdb_core uut (.clk(clk), .nrst(nrst), .cke(cke), .cs_n(cs_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
        .addr(addr), .data_mask(data_mask), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .bank_open(bank_open), .self_refresh(self_refresh),
        .refresh_row(refresh_row), .mode_word(mode_word));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************
    // checking and closing
    // ****************
    task chk(input logic [12:0] seen, input logic [12:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d failures %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    function automatic logic [9:0] ecol(input logic [9:0] s, input int k,
                                        input logic [9:0] msk, input logic il);
        logic [9:0] o;
        o = il ? (s ^ k[9:0]) : (s + k[9:0]);
        return (s & ~msk) | (o & msk);
    endfunction : ecol

    function automatic logic [7:0] dat(input logic [9:0] c);
        return c[7:0] ^ 8'h5a;
    endfunction : dat

    function automatic logic [9:0] bmask(input logic [2:0] bl);
        return (bl == 3'h7) ? 10'h3ff : (10'h001 << bl) - 10'h001;
    endfunction : bmask

    // ****************
    // access tasks
    // ****************
    task cfg(input logic [11:0] op);
        u_ctl.issue(4'b0010, 1'b1, 2'h0, 13'h0400, 1'b0, 8'h00);
        u_ctl.load(op);
        u_ctl.issue(4'b0011, 1'b1, 2'h1, 13'h1abc, 1'b0, 8'h00);
    endtask : cfg

    task wr(input logic [9:0] s, input logic [2:0] bl, input logic m);
        int k;
        u_ctl.issue(4'b0100, 1'b1, 2'h1, {3'h0, s}, m, m ? 8'hff : dat(s));
        for (k = 1; k <= bmask(bl); k++)
            u_ctl.nop(1'b0, dat(ecol(s, k, bmask(bl), 1'b0)));
        u_ctl.idle();
    endtask : wr

    task rd(input logic [11:0] op, input logic [9:0] s, input logic ap);
        logic [9:0] msk;
        int n;
        int k;
        msk = bmask(op[2:0]);
        n = (msk == 10'h3ff) ? 4 : msk + 1;
        cfg(op);
        u_ctl.issue(4'b0101, 1'b1, 2'h1, {2'h0, ap, s}, 1'b0, ~dq_in);
        repeat (op[6:4] - 2) u_ctl.idle();
        chk(dq_oe, 1'b0);
        u_ctl.idle();
        for (k = 0; k < n; k++) begin
            chk(dq_oe, 1'b1);
            chk(dq_out, dat(ecol(s, k, msk, op[3])));
            u_ctl.idle();
        end
        if (msk == 10'h3ff) begin
            u_ctl.issue(4'b0110, 1'b1, 2'h1, 13'h0000, 1'b0, 8'h00);
        end else begin
            chk(dq_oe, 1'b0);
            u_ctl.idle();
            chk(bank_open[1], !ap);
        end
    endtask : rd

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end

    initial begin
        n_fail = 0;
        checked = 0;
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        chk(mode_word, 12'h032);
        chk({dq_oe, self_refresh, bank_open}, 6'h00);
        chk(refresh_row, 13'h0000);
        cfg(12'h028);
        chk(bank_open, 4'h2);
        for (int i = 0; i < 5; i++)
            wr(pg[i], 3'h0, 1'b0);
        wr(10'h005, 3'h0, 1'b1);
        cfg(12'h023);
        wr(10'h00b, 3'h3, 1'b0);
        // single-word writes: the second word must not land
        cfg(12'h221);
        u_ctl.issue(4'b0100, 1'b1, 2'h1, 13'h000e, 1'b0, dat(10'h00e));
        u_ctl.nop(1'b0, ~dat(10'h00f));
        rd(12'h021, 10'h00e, 1'b0);
        rd(12'h023, 10'h00d, 1'b1);
        rd(12'h03b, 10'h00b, 1'b0);
        rd(12'h032, 10'h00a, 1'b0);
        rd(12'h02a, 10'h009, 1'b1);
        rd(12'h021, 10'h00f, 1'b0);
        rd(12'h039, 10'h008, 1'b0);
        rd(12'h028, 10'h005, 1'b0);
        // mask at the read edge floats the word driven one edge later
        u_ctl.issue(4'b0101, 1'b1, 2'h1, 13'h0005, 1'b1, 8'h00);
        u_ctl.idle();
        chk(dq_oe, 1'b0);
        rd(12'h027, 10'h3fe, 1'b0);
        u_ctl.issue(4'b0011, 1'b1, 2'h2, 13'h0005, 1'b0, 8'h00);
        chk(bank_open, 4'h6);
        u_ctl.issue(4'b0010, 1'b1, 2'h1, 13'h0000, 1'b0, 8'h00);
        chk(bank_open, 4'h4);
        u_ctl.issue(4'b0010, 1'b1, 2'h1, 13'h0400, 1'b0, 8'h00);
        chk(bank_open, 4'h0);
        u_ctl.issue(4'b0001, 1'b1, 2'h3, 13'h1fff, 1'b1, 8'h00);
        chk(refresh_row, 13'h0001);
        chk(mode_word, 12'h027);
        u_ctl.issue(4'b1000, 1'b1, 2'h0, 13'h0155, 1'b0, 8'h00);
        chk(mode_word, 12'h027);
        u_ctl.issue(4'b0001, 1'b0, 2'h0, 13'h0000, 1'b0, 8'h00);
        chk(self_refresh, 1'b1);
        u_ctl.issue(4'b0000, 1'b0, 2'h0, 13'h0111, 1'b0, 8'h00);
        chk(mode_word, 12'h027);
        u_ctl.issue(4'b0111, 1'b1, 2'h0, 13'h1eee, 1'b0, 8'h00);
        chk(self_refresh, 1'b0);
        chk(refresh_row, 13'h0002);
        u_ctl.idle();
        u_ctl.idle();
        wrap_up();
    end
endmodule : tb_top
